// *** rtl/dds_cfg_pkg.sv ***
// Shared constants for the clock multiplier, converter and ramp configuration registers.
// Assumes a single core clock domain and a register access port decoded upstream.
package dds_cfg_pkg;

    // Register word addresses on the programming port.
    localparam logic [4:0] ADDR_CLK_MULT_CTRL = 5'h02;
    localparam logic [4:0] ADDR_CONV_CAL_CTRL = 5'h03;
    localparam logic [4:0] ADDR_RAMP_LOWER = 5'h04;
    localparam logic [4:0] ADDR_RAMP_UPPER = 5'h05;
    localparam logic [4:0] ADDR_RAMP_RISE = 5'h06;
    localparam logic [4:0] ADDR_RAMP_FALL = 5'h07;
    localparam logic [4:0] ADDR_USER_STATUS = 5'h1B;

    // Clock multiplier control fields.
    localparam int MULT_EN_BIT = 18;
    localparam int FB_DIV_MSB = 15;
    localparam int FB_DIV_LSB = 8;
    localparam int CP_MANUAL_BIT = 6;
    localparam int CP_CODE_MSB = 5;
    localparam int CP_CODE_LSB = 3;
    localparam int LOCK_DET_EN_BIT = 2;
    localparam int LOCK_WIN_MSB = 1;
    localparam int LOCK_WIN_LSB = 0;

    // Converter calibration control fields.
    localparam int AUX_DIV_PD_BIT = 26;
    localparam int CAL_CLK_PD_BIT = 25;
    localparam int CAL_START_BIT = 24;
    localparam int CONV_FIXED_MSB = 23;

    // User status field.
    localparam int LOCK_STATUS_BIT = 24;

    // Reset values: feedback divider of 25 gives a total multiplication of 50.
    localparam logic [7:0] FB_DIV_RESET = 8'h19;
    localparam logic [31:0] CLK_MULT_RESET = 32'h0000_1900;
    localparam logic [31:0] CONV_CAL_RESET = 32'h0000_0000;
    localparam logic [31:0] RAMP_RESET = 32'h0000_0000;

    // Lock window lengths in reference clock cycles, by window code.
    localparam logic [10:0] LOCK_WIN_128 = 11'h080;
    localparam logic [10:0] LOCK_WIN_256 = 11'h100;
    localparam logic [10:0] LOCK_WIN_512 = 11'h200;
    localparam logic [10:0] LOCK_WIN_1024 = 11'h400;

    typedef enum logic [1:0] {
        LOCK_IDLE = 2'b00,
        LOCK_QUALIFY = 2'b01,
        LOCK_HELD = 2'b10
    } lock_state_e;

endpackage

// *** rtl/dds_pll_dac_ramp_config_regs.sv ***
// Configuration registers for the clock multiplier, converter calibration and ramp limits.
// Assumes the programming port logic delivers single-cycle word writes and reads on core_clk.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - Feedback divider is bits 15:8; total multiplication is twice its value.
// - Feedback divider resets to 25, so total multiplication is 50.
// - Bit 6 clear picks automatic charge pump current; set uses manual code.
// - Bits 5:3 hold the manual charge pump code, used only when manual.
// - Bit 2 enables lock detection; cleared means no lock detection.
// - Lock after error stays in window 128/256/512/1024 reference cycles, bits 1:0.
// - Converter bit 26 set disables sync output circuitry; clear enables it.
// - Calibration clock runs only when bits 25 and 26 are both clear.
// - Writing 1 to converter bit 24 starts an automatic converter calibration.
// - Offset 0x04 holds the 32-bit ramp lower limit.
// - Offset 0x05 holds the 32-bit ramp upper limit.
// - Offset 0x06 holds the 32-bit rising step added per step.
// - Offset 0x07 holds the 32-bit falling step subtracted per step.
// - Ramp registers matter only while ramp enable is set.
// - Read-only status bit 24 reads 1 when locked, 0 otherwise.
// - Bit 18 enables the clock multiplier as system clock source.
module dds_pll_dac_ramp_config_regs #(
    // Lock qualification counter width; it must hold the longest window length.
    parameter int LOCK_COUNT_W = 11
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register access from the programming port.
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [4:0] regAddr,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // Ramp enable from the ramp mode control register.
    input wire logic rampEnable,
    // Analog side status pins, asynchronous to core_clk.
    input wire logic refClkPin,
    input wire logic phaseInWindowPin,
    // Charge pump code chosen by the oscillator calibration routine.
    input wire logic [2:0] autoChargePumpCode,
    // Clock multiplier controls.
    output logic multiplierEnable,
    output logic [7:0] feedbackDivider,
    output logic [8:0] totalMultiplication,
    output logic chargePumpManual,
    output logic [2:0] chargePumpCurrent,
    output logic lockDetectEnable,
    output logic multiplierLocked,
    // Converter controls.
    output logic syncOutEnable,
    output logic calClockEnable,
    output logic dacCalStart,
    // Ramp parameters.
    output logic rampParamsActive,
    output logic [31:0] rampLowerLimit,
    output logic [31:0] rampUpperLimit,
    output logic [31:0] rampRisingStep,
    output logic [31:0] rampFallingStep
);
    import dds_cfg_pkg::*;

    logic [31:0] clkMultCtrl_r;
    logic [31:0] convCalCtrl_r;
    logic [31:0] rampLower_r;
    logic [31:0] rampUpper_r;
    logic [31:0] rampRise_r;
    logic [31:0] rampFall_r;
    logic calStart_r;
    logic [31:0] rdData_r;
    logic rdValid_r;
    logic [31:0] rdData_nxt;

    // Synchroniser stages and lock detection state.
    logic refSync1_r;
    logic refSync2_r;
    logic refPrev_r;
    logic winSync1_r;
    logic winSync2_r;
    logic refEdge;
    logic [LOCK_COUNT_W-1:0] lockCount_r;
    logic [LOCK_COUNT_W-1:0] lockTarget;
    logic locked_r;
    lock_state_e lockState_r;
    lock_state_e lockState_nxt;

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Refuse at elaboration what the logic cannot serve; a package edit that breaks a field stops here.
    // A narrower counter cannot reach the longest window; a wider one up to 16 bits only costs flops.
    if (LOCK_COUNT_W < 11 || LOCK_COUNT_W > 16) begin : gen_bad_count_width
        $error("Lock counter width must be 11 to 16 bits.");
    end
    if (FB_DIV_MSB - FB_DIV_LSB != 7) begin : gen_bad_divider_field
        $error("Feedback divider field must be 8 bits wide.");
    end
    if (FB_DIV_RESET < 8'h0A) begin : gen_bad_divider_reset
        $error("Feedback divider reset value is below the valid range.");
    end
    if (CLK_MULT_RESET[FB_DIV_MSB:FB_DIV_LSB] != FB_DIV_RESET) begin : gen_bad_mult_reset
        $error("Multiplier control reset word disagrees with the divider reset value.");
    end
    if (CP_CODE_MSB - CP_CODE_LSB != 2) begin : gen_bad_cp_field
        $error("Charge pump code field must be 3 bits wide.");
    end
    if (LOCK_WIN_MSB - LOCK_WIN_LSB != 1) begin : gen_bad_window_field
        $error("Lock window field must be 2 bits wide.");
    end
    if (MULT_EN_BIT <= FB_DIV_MSB || CP_MANUAL_BIT >= FB_DIV_LSB) begin : gen_mult_overlap
        $error("Multiplier control fields overlap.");
    end
    if (CONV_FIXED_MSB >= CAL_START_BIT || CAL_CLK_PD_BIT >= AUX_DIV_PD_BIT) begin : gen_conv_overlap
        $error("Converter control fields overlap.");
    end
    if (CONV_CAL_RESET[CAL_START_BIT] != 1'b0) begin : gen_bad_conv_reset
        $error("Calibration start must reset clear because it is never stored.");
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Clock multiplier control register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkMultCtrl_r <= CLK_MULT_RESET;
        end else if (regWrEn && regAddr == ADDR_CLK_MULT_CTRL) begin
            clkMultCtrl_r <= regWrData;
        end
    end

    // Converter calibration control; the start bit is never stored so it reads back as zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            convCalCtrl_r <= CONV_CAL_RESET;
        end else if (regWrEn && regAddr == ADDR_CONV_CAL_CTRL) begin
            convCalCtrl_r <= regWrData;
            convCalCtrl_r[CAL_START_BIT] <= 1'b0;
        end
    end

    // One cycle high per write of 1; back-to-back writes merge into one longer pulse.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            calStart_r <= 1'b0;
        end else begin
            calStart_r <= regWrEn && regAddr == ADDR_CONV_CAL_CTRL && regWrData[CAL_START_BIT];
        end
    end

    // Ramp parameter registers.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rampLower_r <= RAMP_RESET;
            rampUpper_r <= RAMP_RESET;
            rampRise_r <= RAMP_RESET;
            rampFall_r <= RAMP_RESET;
        end else if (regWrEn) begin
            if (regAddr == ADDR_RAMP_LOWER) begin
                rampLower_r <= regWrData;
            end else if (regAddr == ADDR_RAMP_UPPER) begin
                rampUpper_r <= regWrData;
            end else if (regAddr == ADDR_RAMP_RISE) begin
                rampRise_r <= regWrData;
            end else if (regAddr == ADDR_RAMP_FALL) begin
                rampFall_r <= regWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Read path, one cycle of latency; unmapped addresses read as zero.
    always_comb begin
        rdData_nxt = 32'h0000_0000;
        if (regAddr == ADDR_CLK_MULT_CTRL) begin
            rdData_nxt = clkMultCtrl_r;
        end else if (regAddr == ADDR_CONV_CAL_CTRL) begin
            rdData_nxt = convCalCtrl_r;
        end else if (regAddr == ADDR_RAMP_LOWER) begin
            rdData_nxt = rampLower_r;
        end else if (regAddr == ADDR_RAMP_UPPER) begin
            rdData_nxt = rampUpper_r;
        end else if (regAddr == ADDR_RAMP_RISE) begin
            rdData_nxt = rampRise_r;
        end else if (regAddr == ADDR_RAMP_FALL) begin
            rdData_nxt = rampFall_r;
        end else if (regAddr == ADDR_USER_STATUS) begin
            rdData_nxt[LOCK_STATUS_BIT] = locked_r;
        end
    end

    // Read data holds until the next read, so a slow host may pick it up late.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= 32'h0000_0000;
        end else if (regRdEn) begin
            rdData_r <= rdData_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= regRdEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Both status pins come from the analog side and pass two flops before use.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            refSync1_r <= 1'b0;
            refSync2_r <= 1'b0;
            refPrev_r <= 1'b0;
        end else begin
            refSync1_r <= refClkPin;
            refSync2_r <= refSync1_r;
            refPrev_r <= refSync2_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            winSync1_r <= 1'b0;
            winSync2_r <= 1'b0;
        end else begin
            winSync1_r <= phaseInWindowPin;
            winSync2_r <= winSync1_r;
        end
    end

    // The reference clock must stay below half of core_clk for every edge to be seen.
    assign refEdge = refSync2_r && !refPrev_r;

    always_comb begin
        case (clkMultCtrl_r[LOCK_WIN_MSB:LOCK_WIN_LSB])
            2'b00: lockTarget = LOCK_COUNT_W'(LOCK_WIN_128);
            2'b01: lockTarget = LOCK_COUNT_W'(LOCK_WIN_256);
            2'b10: lockTarget = LOCK_COUNT_W'(LOCK_WIN_512);
            default: lockTarget = LOCK_COUNT_W'(LOCK_WIN_1024);
        endcase
    end

    always_comb begin
        lockState_nxt = lockState_r;
        case (lockState_r)
            LOCK_IDLE: begin
                if (clkMultCtrl_r[LOCK_DET_EN_BIT] && winSync2_r) begin
                    lockState_nxt = LOCK_QUALIFY;
                end
            end
            LOCK_QUALIFY: begin
                if (refEdge && lockCount_r == lockTarget - LOCK_COUNT_W'(1)) begin
                    lockState_nxt = LOCK_HELD;
                end
            end
            LOCK_HELD: begin
                lockState_nxt = LOCK_HELD;
            end
            default: begin
                lockState_nxt = LOCK_IDLE;
            end
        endcase
        if (!clkMultCtrl_r[LOCK_DET_EN_BIT] || !winSync2_r) begin
            lockState_nxt = LOCK_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockState_r <= LOCK_IDLE;
        end else begin
            lockState_r <= lockState_nxt;
        end
    end

    // Registered flag, so a window loss or a disable drops it on the next edge.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_r <= 1'b0;
        end else begin
            locked_r <= lockState_nxt == LOCK_HELD;
        end
    end

    // The edge that brings the window in is not counted: only whole cycles inside it qualify.
    // count reference cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockCount_r <= '0;
        end else if (lockState_nxt != LOCK_QUALIFY) begin
            lockCount_r <= '0;
        end else if (refEdge && lockState_r == LOCK_QUALIFY) begin
            lockCount_r <= lockCount_r + LOCK_COUNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    assign multiplierEnable = clkMultCtrl_r[MULT_EN_BIT];
    assign feedbackDivider = clkMultCtrl_r[FB_DIV_MSB:FB_DIV_LSB];
    assign totalMultiplication = {clkMultCtrl_r[FB_DIV_MSB:FB_DIV_LSB], 1'b0};
    assign chargePumpManual = clkMultCtrl_r[CP_MANUAL_BIT];
    assign chargePumpCurrent = clkMultCtrl_r[CP_MANUAL_BIT] ? clkMultCtrl_r[CP_CODE_MSB:CP_CODE_LSB]
                                                            : autoChargePumpCode;
    assign lockDetectEnable = clkMultCtrl_r[LOCK_DET_EN_BIT];
    assign multiplierLocked = locked_r;
    assign syncOutEnable = !convCalCtrl_r[AUX_DIV_PD_BIT];
    assign calClockEnable = !convCalCtrl_r[CAL_CLK_PD_BIT] && !convCalCtrl_r[AUX_DIV_PD_BIT];
    assign dacCalStart = calStart_r;
    assign rampParamsActive = rampEnable;
    assign rampLowerLimit = rampLower_r;
    assign rampUpperLimit = rampUpper_r;
    assign rampRisingStep = rampRise_r;
    assign rampFallingStep = rampFall_r;
    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;

endmodule

// *** testbench/dds_cfg_properties.sv ***
// Port checker for the configuration register block.
// Assumes one core clock with an asynchronous active-low reset.
`timescale 1ns/1ps
module dds_cfg_properties
    import dds_cfg_pkg::*;
(
    // Clock, reset and register writes.
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic regWrEn,
    input wire logic [4:0] regAddr,
    input wire logic [31:0] regWrData,
    // Side inputs and block outputs.
    input wire logic rampEnable,
    input wire logic phaseInWindowPin,
    input wire logic [2:0] autoChargePumpCode,
    input wire logic [7:0] feedbackDivider,
    input wire logic [8:0] totalMultiplication,
    input wire logic chargePumpManual,
    input wire logic [2:0] chargePumpCurrent,
    input wire logic lockDetectEnable,
    input wire logic multiplierLocked,
    input wire logic syncOutEnable,
    input wire logic calClockEnable,
    input wire logic dacCalStart,
    input wire logic rampParamsActive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic multWr = regWrEn && regAddr == ADDR_CLK_MULT_CTRL;
    wire logic calWr = regWrEn && regAddr == ADDR_CONV_CAL_CTRL;
    ////////////////////////////////////////////////////////////
    sequence calPulse;
        dacCalStart ##1 !dacCalStart;
    endsequence
    sequence calRequest;
        calWr && regWrData[CAL_START_BIT] ##1 !calWr;
    endsequence
    sequence windowLost;
        !phaseInWindowPin [*3];
    endsequence
    mult_double_a: assert property (totalMultiplication == {feedbackDivider, 1'b0})
        else $error("Total multiplication is not twice the divider.");
    div_write_a: assert property (multWr |=> feedbackDivider == $past(regWrData[FB_DIV_MSB:FB_DIV_LSB]))
        else $error("Divider write was not applied.");
    cp_auto_a: assert property (!chargePumpManual |-> chargePumpCurrent == autoChargePumpCode)
        else $error("Automatic charge pump code not used.");
    lock_off_a: assert property (!lockDetectEnable |=> !multiplierLocked)
        else $error("Lock reported with detection off.");
    sync_out_a: assert property (calWr |=> syncOutEnable == !$past(regWrData[AUX_DIV_PD_BIT]))
        else $error("Sync output enable wrong.");
    cal_clock_a: assert property (calWr |=> calClockEnable == !($past(regWrData[26]) || $past(regWrData[25])))
        else $error("Calibration clock enable wrong.");
    cal_cause_a: assert property (dacCalStart |-> $past(calWr && regWrData[CAL_START_BIT]))
        else $error("Calibration start without a write.");
    cal_pulse_a: assert property (calRequest |-> calPulse)
        else $error("Calibration start is not one pulse.");
    ramp_active_a: assert property (rampParamsActive == rampEnable)
        else $error("Ramp active flag differs from ramp enable.");
    cp_manual_a: assert property (multWr && regWrData[CP_MANUAL_BIT] |=>
        chargePumpCurrent == $past(regWrData[CP_CODE_MSB:CP_CODE_LSB]))
        else $error("Manual charge pump code not applied.");
    lock_loss_a: assert property (windowLost |=> !multiplierLocked)
        else $error("Lock held after the window was lost.");
endmodule
bind dds_pll_dac_ramp_config_regs dds_cfg_properties u_dds_cfg_properties (.core_clk, .rst_n, .regWrEn, .regAddr,
    .regWrData, .rampEnable, .autoChargePumpCode, .feedbackDivider, .totalMultiplication, .chargePumpManual,
    .chargePumpCurrent, .lockDetectEnable, .multiplierLocked, .syncOutEnable, .calClockEnable, .dacCalStart,
    .rampParamsActive, .phaseInWindowPin);

// *** testbench/analog_side_model.sv ***
// Model of the analog side: a free-running reference clock and the phase window flag.
// Assumes the bench sets inWindow to say whether the phase error sits in the window.
`timescale 1ns/1ps
module analog_side_model #(
    parameter int HALF_NS = 200
) (
    // Bench control.
    input wire logic inWindow,
    // Pins into the block.
    output logic refClkPin,
    output logic phaseInWindowPin
);
    initial refClkPin = 1'b0;
    initial phaseInWindowPin = 1'b0;
    always #(HALF_NS) refClkPin = ~refClkPin;
    // The flag moves on reference edges only, as a phase detector reports it.
    always @(posedge refClkPin) phaseInWindowPin <= inWindow;
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the configuration register block.
// Assumes the analog side model drives the reference clock, eight core cycles a period.
`timescale 1ns/1ps
module testbench;
    import dds_cfg_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic rampEnable = 1'b0;
    logic inWindow = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [31:0] regWrData = 32'h0;
    logic [2:0] autoChargePumpCode = 3'h2;
    logic [31:0] regRdData, rampLowerLimit, rampUpperLimit, rampRisingStep, rampFallingStep;
    logic regRdValid, refClkPin, phaseInWindowPin, multiplierEnable, chargePumpManual, lockDetectEnable;
    logic multiplierLocked, syncOutEnable, calClockEnable, dacCalStart, rampParamsActive;
    logic [7:0] feedbackDivider;
    logic [8:0] totalMultiplication;
    logic [2:0] chargePumpCurrent;
    int failures = 0;
    int nCompared = 0;
    always #25 core_clk = ~core_clk;
    dds_pll_dac_ramp_config_regs u_dds_pll_dac_ramp_config_regs (.core_clk, .rst_n, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regRdValid, .rampEnable, .refClkPin, .phaseInWindowPin, .autoChargePumpCode,
        .multiplierEnable, .feedbackDivider, .totalMultiplication, .chargePumpManual, .chargePumpCurrent,
        .lockDetectEnable, .multiplierLocked, .syncOutEnable, .calClockEnable, .dacCalStart, .rampParamsActive,
        .rampLowerLimit, .rampUpperLimit, .rampRisingStep, .rampFallingStep);
    analog_side_model u_analog_side_model (.inWindow, .refClkPin, .phaseInWindowPin);
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        #1;
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge core_clk);
        #1;
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
        @(posedge core_clk);
        #1;
        regRdEn = 1'b1;
        regAddr = a;
        @(posedge core_clk);
        #1;
        regRdEn = 1'b0;
        check("read valid", 32'h1, {31'h0, regRdValid});
        check(what, exp, regRdData);
    endtask
    // The reference edge that raises the window flag may wait up to one period.
    // Lock may not come before the whole window of reference cycles has passed.
    task automatic wait_lock(input int cyc);
        int n;
        n = 0;
        while (multiplierLocked !== 1'b1 && n < cyc + 24) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= cyc + 24) begin
            failures++;
            $display("MISMATCH lock wait expected lock seen none");
            wrap_up();
        end
        check("lock delay", 32'h1, 32'(n > cyc));
    endtask
    task automatic wrap_up;
        $display("Compared %0d, failures %0d.", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        rd(ADDR_CLK_MULT_CTRL, CLK_MULT_RESET, "mult reset");
        check("total reset", 32'h32, {23'h0, totalMultiplication});
        rd(ADDR_CONV_CAL_CTRL, CONV_CAL_RESET, "conv reset");
        $display("Test reset values done.");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_RAMP_LOWER + 5'(i), 32'hA5A5_0000 | 32'(i));
        end
        check("lower", 32'hA5A5_0000, rampLowerLimit);
        check("upper", 32'hA5A5_0001, rampUpperLimit);
        check("rise", 32'hA5A5_0002, rampRisingStep);
        check("fall", 32'hA5A5_0003, rampFallingStep);
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_RAMP_LOWER + 5'(i), 32'hA5A5_0000 | 32'(i), "ramp read");
        end
        wr(ADDR_USER_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_USER_STATUS, 32'h0, "status");
        rd(5'h08, 32'h0, "unmapped");
        rampEnable = 1'b1;
        #1;
        check("ramp active", 32'h1, {31'h0, rampParamsActive});
        $display("Test ramp registers done.");
        wr(ADDR_CLK_MULT_CTRL, 32'h0004_FF6C);
        check("mult en", 32'h1, {31'h0, multiplierEnable});
        check("total", 32'h1FE, {23'h0, totalMultiplication});
        check("manual cp", 32'h5, {29'h0, chargePumpCurrent});
        check("cp manual", 32'h1, {31'h0, chargePumpManual});
        check("detect on", 32'h1, {31'h0, lockDetectEnable});
        check("divider", 32'hFF, {24'h0, feedbackDivider});
        autoChargePumpCode = 3'h6;
        wr(ADDR_CLK_MULT_CTRL, 32'h0000_0A28);
        check("auto cp", 32'h6, {29'h0, chargePumpCurrent});
        check("cp auto flag", 32'h0, {31'h0, chargePumpManual});
        check("mult off", 32'h0, {31'h0, multiplierEnable});
        check("total min", 32'h14, {23'h0, totalMultiplication});
        $display("Test multiplier control done.");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONV_CAL_CTRL, {5'h0, 2'(i), 1'b1, 24'h0});
            check("cal start", 32'h1, {31'h0, dacCalStart});
            check("sync out", 32'(i < 2), {31'h0, syncOutEnable});
            check("cal clock", 32'(i == 0), {31'h0, calClockEnable});
            rd(ADDR_CONV_CAL_CTRL, {5'h0, 2'(i), 25'h0}, "conv read");
            check("cal ended", 32'h0, {31'h0, dacCalStart});
        end
        $display("Test converter control done.");
        wr(ADDR_CLK_MULT_CTRL, CLK_MULT_RESET);
        inWindow = 1'b1;
        repeat (1100) @(posedge core_clk);
        #1;
        check("no lock", 32'h0, {31'h0, multiplierLocked});
        for (int c = 0; c < 4; c++) begin
            inWindow = 1'b0;
            wr(ADDR_CLK_MULT_CTRL, 32'h0000_1904 | 32'(c));
            repeat (20) @(posedge core_clk);
            #1;
            check("lock cleared", 32'h0, {31'h0, multiplierLocked});
            inWindow = 1'b1;
            wait_lock(1024 << c);
            rd(ADDR_USER_STATUS, 32'h0100_0000, "lock status");
        end
        wr(ADDR_CLK_MULT_CTRL, 32'h0000_3203);
        @(posedge core_clk);
        #1;
        check("lock dropped", 32'h0, {31'h0, multiplierLocked});
        $display("Test lock detection done.");
        rst_n = 1'b0;
        @(posedge core_clk);
        #1;
        check("reset divider", {24'h0, FB_DIV_RESET}, {24'h0, feedbackDivider});
        check("reset sync", 32'h1, {31'h0, syncOutEnable});
        check("reset cal clock", 32'h1, {31'h0, calClockEnable});
        rst_n = 1'b1;
        rd(ADDR_CONV_CAL_CTRL, CONV_CAL_RESET, "conv after reset");
        $display("Test mid-run reset done.");
        wrap_up();
    end
endmodule
